// *** disk_rw_flux_codec.sv ***
// What this block does
// R1 - Write toggle held reset whenever write mode is not asserted.
// R2 - Each write flux pulse inverts the toggle; its two outputs drive head halves.
// R3 - High write current on tracks 0 to 255, reduced on 256 to 405.
// R4 - Erase drive follows its own enable, independent of write mode.
// R5 - No write or erase return path unless power good is high.
// R6 - Read path disconnected during write; reconnected only with write and erase off.
// R7 - Read mode only when write mode and erase enable are both high.
// R8 - One composite pulse per zero crossing of the squared read signal.
// R9 - Clock pulse every cell boundary; an extra mid-cell pulse per one bit.
// R10 - Each clock pulse opens a ones window, short after a one, else long.
// R11 - Pulse inside the window is data and selects the short window next.
// R12 - Separated clock and data pulses stretched to adjustable widths.
// R13 - Write fault rises on either emergency condition and starts an unload.
// R14 - Unload drops ready and write current within one microsecond.
// R15 - Unload opens the relay and removes the head driver return supply.
// R16 - Write fault when more than one head is selected while writing.
// R17 - Write fault on stray write or erase current in read mode only.
// R18 - Stray current fault masked for a while after read/write switching.
// R19 - Current setting from the track address weight-256 bit and write mode.
// R20 - Controller sends double-frequency flux pulses only during write mode.
`include "disk_rw_params.svh"
`timescale 1ns/10ps
`default_nettype none
module disk_rw_flux_codec
    import disk_rw_pkg::*;
#(
    parameter int HEADS = 8
) (
    input  wire logic             mclk,
    input  wire logic             rst_n,
    input  wire logic [7:0]       s_axi_awaddr,
    input  wire logic             s_axi_awvalid,
    output var  logic             s_axi_awready,
    input  wire logic [31:0]      s_axi_wdata,
    input  wire logic [3:0]       s_axi_wstrb,
    input  wire logic             s_axi_wvalid,
    output var  logic             s_axi_wready,
    output var  logic [1:0]       s_axi_bresp,
    output var  logic             s_axi_bvalid,
    input  wire logic             s_axi_bready,
    input  wire logic [7:0]       s_axi_araddr,
    input  wire logic             s_axi_arvalid,
    output var  logic             s_axi_arready,
    output var  logic [31:0]      s_axi_rdata,
    output var  logic [1:0]       s_axi_rresp,
    output var  logic             s_axi_rvalid,
    input  wire logic             s_axi_rready,
    input  wire logic             write_mode_n,
    input  wire logic             write_flux_pulse_n,
    input  wire logic             erase_enable_n,
    input  wire logic             power_good_level,
    input  wire logic             track_upper_half,
    input  wire logic [HEADS-1:0] head_select,
    input  wire logic             current_sense,
    input  wire logic             read_square,
    output var  logic             write_drive_true,
    output var  logic             write_drive_comp,
    output var  logic             high_write_current,
    output var  logic             erase_drive,
    output var  logic             read_switch_on,
    output var  logic             composite_pulse,
    output var  logic             sep_clock,
    output var  logic             sep_data,
    output var  logic             write_fault,
    output var  logic             write_fault_n,
    output var  logic             drive_ready,
    output var  logic             unload_relay_open,
    output var  logic             head_driver_return_supply
);

    // The head check needs at least two heads to have a meaning.
    if (HEADS < 2 || HEADS > 16) begin : g_bad_heads
        $error("HEADS must lie between 2 and 16");
    end

    // More than one bit set in a head select vector.
    function automatic logic multi_select(input logic [HEADS-1:0] v);
        return (v & (v - 1'b1)) != '0;
    endfunction : multi_select

    // ---- Register file and AXI4-Lite slave ----
    word_t        win_reg;
    word_t        str_reg;
    word_t        mask_reg;
    logic [7:0]   aw_addr;
    logic         aw_held;
    word_t        w_data;
    logic [3:0]   w_strb;
    logic         w_held;
    logic         rearm_pulse;
    word_t        status_word;
    word_t        next_rdata;
    logic         next_rerr;
    wire          aw_fire = s_axi_awvalid && s_axi_awready;
    wire          w_fire  = s_axi_wvalid && s_axi_wready;
    wire          ar_fire = s_axi_arvalid && s_axi_arready;
    wire          do_write = aw_held && w_held && !s_axi_bvalid;
    wire          wr_win   = do_write && aw_addr == `REG_WINDOW;
    wire          wr_str   = do_write && aw_addr == `REG_STRETCH;
    wire          wr_mask  = do_write && aw_addr == `REG_MASK;
    wire          wr_ctrl  = do_write && aw_addr == `REG_CONTROL;
    wire          wr_ok    = wr_win || wr_str || wr_mask || wr_ctrl;
    wire   word_t strb_mask = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};

    // Byte-lane merge applied to the window, stretch and mask registers.
    function automatic word_t merge(input word_t old, input word_t nw, input word_t m);
        return (old & ~m) | (nw & m);
    endfunction : merge

    // Address and data are taken independently and held until both arrived.
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            aw_held <= 1'b0;
            w_held  <= 1'b0;
            aw_addr <= 8'h00;
            w_data  <= 32'h0000_0000;
            w_strb  <= 4'h0;
        end else begin
            if (aw_fire) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end else if (do_write) begin
                aw_held <= 1'b0;
            end
            if (w_fire) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end else if (do_write) begin
                w_held <= 1'b0;
            end
        end
    end

    // Ready flags drop once a beat is held and return after the response.
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= 2'h0;
        end else begin
            s_axi_awready <= !aw_held && !aw_fire && !s_axi_bvalid && !do_write;
            s_axi_wready  <= !w_held && !w_fire && !s_axi_bvalid && !do_write;
            if (do_write) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_ok ? 2'h0 : 2'h2;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Writable registers; the control word only yields a one-cycle rearm strobe.
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            win_reg     <= `WINDOW_RESET;
            str_reg     <= `STRETCH_RESET;
            mask_reg    <= `MASK_RESET;
            rearm_pulse <= 1'b0;
        end else begin
            if (wr_win)  win_reg  <= merge(win_reg, w_data, strb_mask) & 32'h0000_FFFF;
            if (wr_str)  str_reg  <= merge(str_reg, w_data, strb_mask) & 32'h0000_FFFF;
            if (wr_mask) mask_reg <= merge(mask_reg, w_data, strb_mask) & 32'h0000_00FF;
            rearm_pulse <= wr_ctrl && w_strb[0] && w_data[`CTRL_REARM_BIT];
        end
    end

    // Read decode; an unmapped address answers SLVERR with zero data.
    always_comb begin
        next_rerr = 1'b0;
        unique case (s_axi_araddr)
            `REG_WINDOW:  next_rdata = win_reg;
            `REG_STRETCH: next_rdata = str_reg;
            `REG_MASK:    next_rdata = mask_reg;
            `REG_STATUS:  next_rdata = status_word;
            `REG_CONTROL: next_rdata = 32'h0000_0000;
            default: begin
                next_rdata = 32'h0000_0000;
                next_rerr  = 1'b1;
            end
        endcase
    end

    // One read at a time; the answer comes the cycle after the address.
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= 2'h0;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !ar_fire;
            if (ar_fire) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= next_rdata;
                s_axi_rresp  <= next_rerr ? 2'h2 : 2'h0;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // ---- Mode decode and write path ----
    drive_state_e drive_state;
    drive_state_e next_drive_state;
    logic         toggle;
    logic         flux_q;
    wire          writing   = !write_mode_n;
    wire          erasing   = !erase_enable_n;
    wire          read_mode = write_mode_n && erase_enable_n;  // R7
    wire          unload    = drive_state != DRV_READY;
    wire          flux_edge = flux_q && !write_flux_pulse_n;
    wire          ret_ok    = power_good_level && !unload;     // R5 R15

    // A falling flux pulse toggles; leaving write mode clears the toggle.
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            toggle <= 1'b0;
            flux_q <= 1'b1;
        end else begin
            flux_q <= write_flux_pulse_n;
            if (!writing) begin
                toggle <= 1'b0;                                 // R1
            end else if (flux_edge) begin
                toggle <= !toggle;                              // R2
            end
        end
    end

    // Head drivers; every path needs the return supply, so power loss or unload
    // stops all head current even if the controller keeps its enables low.
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            write_drive_true          <= 1'b0;
            write_drive_comp          <= 1'b0;
            high_write_current        <= 1'b0;
            erase_drive               <= 1'b0;
            read_switch_on            <= 1'b0;
            head_driver_return_supply <= 1'b0;
            unload_relay_open         <= 1'b1;
            drive_ready               <= 1'b0;
        end else begin
            write_drive_true          <= writing && ret_ok && next_drive_state == DRV_READY
                                         && (flux_edge ? !toggle : toggle);          // R2 R14
            write_drive_comp          <= writing && ret_ok && next_drive_state == DRV_READY
                                         && (flux_edge ? toggle : !toggle);          // R2 R14
            high_write_current        <= writing && !track_upper_half;               // R3 R19
            erase_drive               <= erasing && ret_ok;                          // R4 R5
            read_switch_on            <= read_mode;                                  // R6
            head_driver_return_supply <= power_good_level && next_drive_state == DRV_READY;
            unload_relay_open         <= next_drive_state != DRV_READY;              // R15
            drive_ready               <= next_drive_state == DRV_READY;              // R14
        end
    end

    // ---- Emergency condition detection ----
    logic         read_mode_q;
    count_t       mask_cnt;
    logic         fault_multi;
    logic         fault_stray;
    wire          multi_now = writing && multi_select(head_select);          // R16
    wire          mask_done = mask_cnt == 8'h00;
    // The mode must also be unchanged since the last edge: on the switching edge
    // itself the mask counter has not been reloaded yet and still reads zero.
    wire          mode_steady = read_mode == read_mode_q;                    // R18
    wire          stray_now = current_sense && read_mode && mode_steady && mask_done;  // R17 R18

    // Any change of mode restarts the mask so switching transients are ignored.
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            read_mode_q <= 1'b1;
            mask_cnt    <= 8'h00;
        end else begin
            read_mode_q <= read_mode;
            if (read_mode != read_mode_q) begin
                mask_cnt <= mask_reg[7:0];                       // R18
            end else if (!mask_done) begin
                mask_cnt <= mask_cnt - 8'h01;
            end
        end
    end

    // Sticky causes for software; a new event wins over a rearm in the same cycle.
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            fault_multi   <= 1'b0;
            fault_stray   <= 1'b0;
            write_fault   <= 1'b0;
            write_fault_n <= 1'b1;
        end else begin
            fault_multi   <= multi_now || (fault_multi && !rearm_pulse);
            fault_stray   <= stray_now || (fault_stray && !rearm_pulse);
            write_fault   <= multi_now || stray_now;            // R13
            write_fault_n <= !(multi_now || stray_now);
        end
    end

    // Unload sequence: a fault or lost power leaves ready at once; the drive
    // stays unloaded until software rearms with power good and no fault.
    always_comb begin
        next_drive_state = drive_state;
        unique case (drive_state)
            DRV_READY: begin
                if (write_fault || !power_good_level) next_drive_state = DRV_UNLOADING;  // R13
            end
            DRV_UNLOADING: next_drive_state = DRV_UNLOADED;
            DRV_UNLOADED: begin
                if (rearm_pulse && power_good_level && !write_fault) next_drive_state = DRV_READY;
            end
            default: next_drive_state = DRV_UNLOADING;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            drive_state <= DRV_UNLOADED;
        end else begin
            drive_state <= next_drive_state;
        end
    end

    // ---- Read channel and data separator ----
    logic         square_q;
    logic         had_one;
    count_t       win_cnt;
    count_t       clk_cnt;
    count_t       dat_cnt;
    wire          crossing  = square_q != read_square;                  // R8
    wire          win_open  = win_cnt != 8'h00;
    wire          is_clock  = crossing && !win_open;                    // R9
    wire          is_data   = crossing && win_open;                     // R9 R11
    wire  count_t win_len   = had_one ? win_reg[`WIN_SHORT_LSB +: 8]
                                      : win_reg[`WIN_LONG_LSB +: 8];    // R10

    // A crossing outside the window is a cell clock and opens the next window.
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            square_q        <= 1'b0;
            composite_pulse <= 1'b0;
            had_one         <= 1'b0;
            win_cnt         <= 8'h00;
        end else begin
            square_q        <= read_square;
            composite_pulse <= crossing;                                 // R8
            if (is_clock) begin
                win_cnt <= win_len;                                      // R10
                had_one <= 1'b0;
            end else begin
                if (win_open) win_cnt <= win_cnt - 8'h01;
                if (is_data) had_one <= 1'b1;                            // R11
            end
        end
    end

    // Stretchers restart on each pulse; a width of zero still gives one cycle.
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            clk_cnt   <= 8'h00;
            dat_cnt   <= 8'h00;
            sep_clock <= 1'b0;
            sep_data  <= 1'b0;
        end else begin
            clk_cnt   <= is_clock ? str_reg[`STR_CLOCK_LSB +: 8]
                                  : (clk_cnt != 8'h00 ? clk_cnt - 8'h01 : 8'h00);  // R12
            dat_cnt   <= is_data ? str_reg[`STR_DATA_LSB +: 8]
                                 : (dat_cnt != 8'h00 ? dat_cnt - 8'h01 : 8'h00);   // R12
            sep_clock <= is_clock || clk_cnt > 8'h01;
            sep_data  <= is_data || dat_cnt > 8'h01;
        end
    end

    assign status_word = {24'h000000, had_one, toggle, read_mode, !mask_done,
                          fault_stray, fault_multi, drive_state};

    // ---- Checks ----
    int unsigned unload_age;
    always_ff @(posedge mclk) begin
        if (!rst_n || !write_fault) unload_age <= 0;
        else if (unload_age < 1000) unload_age <= unload_age + 1;
    end

    a_toggle_idle: assert property (@(posedge mclk) disable iff (!rst_n)
        write_mode_n |=> !toggle) else $error("toggle not cleared out of write");  // R1
    a_toggle_flip: assert property (@(posedge mclk) disable iff (!rst_n)
        (!write_mode_n && flux_edge) |=> toggle != $past(toggle))
        else $error("flux pulse did not toggle");  // R2
    a_current_sel: assert property (@(posedge mclk) disable iff (!rst_n)
        1'b1 |=> high_write_current == ($past(!write_mode_n) && !$past(track_upper_half)))
        else $error("write current setting wrong");  // R3
    a_no_power_drive: assert property (@(posedge mclk) disable iff (!rst_n)
        !power_good_level |=> !write_drive_true && !write_drive_comp && !erase_drive)
        else $error("head current without power good");  // R5
    a_read_switch: assert property (@(posedge mclk) disable iff (!rst_n)
        (!write_mode_n || !erase_enable_n) |=> !read_switch_on)
        else $error("read path connected while writing");  // R6
    a_pulse_crossing: assert property (@(posedge mclk) disable iff (!rst_n)
        $changed(read_square) |=> composite_pulse) else $error("crossing lost");  // R8
    a_data_short: assert property (@(posedge mclk) disable iff (!rst_n)
        is_data |=> had_one ##0 sep_data) else $error("data pulse not taken");  // R11
    a_multi_fault: assert property (@(posedge mclk) disable iff (!rst_n)
        (!write_mode_n && multi_select(head_select)) |=> write_fault)
        else $error("multi head not flagged");  // R16
    a_stray_masked: assert property (@(posedge mclk) disable iff (!rst_n)
        (current_sense && !read_mode) |=> !write_fault || $past(multi_now))
        else $error("stray fault raised while writing");  // R17
    a_unload_fast: assert property (@(posedge mclk) disable iff (!rst_n)
        unload_age == 1 |-> !drive_ready && !write_drive_true && !write_drive_comp
        && unload_relay_open && !head_driver_return_supply)
        else $error("unload slower than limit");  // R14 R15

    c_data_bit:  cover property (@(posedge mclk) disable iff (!rst_n) is_data ##[1:8] is_clock);
    c_fault:     cover property (@(posedge mclk) disable iff (!rst_n) $rose(write_fault));
    c_rearm:     cover property (@(posedge mclk) disable iff (!rst_n) $rose(drive_ready));
    c_write_run: cover property (@(posedge mclk) disable iff (!rst_n) write_drive_true ##1 write_drive_comp);

endmodule : disk_rw_flux_codec
`default_nettype wire

// *** disk_rw_params.svh ***
`ifndef DISK_RW_PARAMS_SVH
`define DISK_RW_PARAMS_SVH

// Register byte offsets on the AXI4-Lite slave.
`define REG_WINDOW        8'h00
`define REG_STRETCH       8'h04
`define REG_MASK          8'h08
`define REG_STATUS        8'h0C
`define REG_CONTROL       8'h10

// Field positions and reset values.
`define WIN_SHORT_LSB     0
`define WIN_LONG_LSB      8
`define STR_CLOCK_LSB     0
`define STR_DATA_LSB      8
`define CTRL_REARM_BIT    0
`define WINDOW_RESET      32'h0000_0403
`define STRETCH_RESET     32'h0000_0202
`define MASK_RESET        32'h0000_0004

// Timing figures and the cycle counts derived from them.
`define CLK_PERIOD_NS     100
`define CELL_NS           640
`define CELL_CYC          ((`CELL_NS) / (`CLK_PERIOD_NS))
`define UNLOAD_LIMIT_NS   1000
`define UNLOAD_LIMIT_CYC  ((`UNLOAD_LIMIT_NS) / (`CLK_PERIOD_NS))

// Current level above which the sense comparator reports stray current.
`define STRAY_CURRENT_UA  700

`endif

// *** disk_rw_pkg.sv ***
package disk_rw_pkg;

    // Drive readiness along the emergency unload path (Gray coded).
    typedef enum logic [1:0] {
        DRV_READY     = 2'b00,
        DRV_UNLOADING = 2'b01,
        DRV_UNLOADED  = 2'b11
    } drive_state_e;

    typedef logic [31:0] word_t;
    typedef logic [7:0]  count_t;

endpackage : disk_rw_pkg

// *** disk_ctrl_model.sv ***
`include "disk_rw_params.svh"
`timescale 1ns/10ps
`default_nettype none
module disk_ctrl_model
    import disk_rw_pkg::*;
(
    input  wire logic       mclk,
    input  wire logic       go,
    input  wire logic       slow,
    input  wire logic [7:0] bits,
    output var  logic       write_mode_n,
    output var  logic       erase_enable_n,
    output var  logic       write_flux_pulse_n,
    output var  logic       done
);
    // One low cycle per pulse, so the line always has a high cycle between pulses.
    task automatic pulse(input int gap);
        write_flux_pulse_n <= 1'b0;
        @(posedge mclk);
        write_flux_pulse_n <= 1'b1;
        repeat (gap) @(posedge mclk);
    endtask : pulse
    // Sends a byte as clock pulses plus mid-cell ones, then holds erase past write mode.
    initial begin
        int h;
        {write_mode_n, erase_enable_n, write_flux_pulse_n, done} = 4'hE;
        forever begin
            @(posedge mclk);
            if (go && !done) begin
                h = (slow ? 2 : 1) * `CELL_CYC / 2;
                erase_enable_n <= 1'b0;
                write_mode_n <= 1'b0;
                repeat (2) @(posedge mclk);
                for (int i = 7; i >= 0; i--) begin
                    pulse(h - 1);
                    if (bits[i]) pulse(h - 1);
                    else repeat (h) @(posedge mclk);
                end
                done <= 1'b1;
            end else if (!go && done) begin
                write_mode_n <= 1'b1;
                repeat (3) @(posedge mclk);
                erase_enable_n <= 1'b1;
                done <= 1'b0;
            end
        end
    end
endmodule : disk_ctrl_model
`default_nettype wire

// *** disk_rw_flux_codec_and_write_fault_tb.sv ***
`include "disk_rw_params.svh"
`timescale 1ns/10ps
`default_nettype none
module disk_rw_flux_codec_and_write_fault_tb;
    logic mclk = 0, rst_n = 0, awv = 0, wv = 0, br = 0, arv = 0, rr = 0;
    logic awr, wr, bv, arr, rv, wdt, wdc, hwc, era, rsw, cp, sc, sd, wf, wfn, rdy, rly, ret;
    logic [7:0] awa = 0, ara = 0, head_select = 8'h01;
    logic [31:0] wd = 0, rd;
    logic [1:0] bre, rre;
    logic tb_wm_n = 1, tb_er_n = 1, up = 0, pg = 1, cs = 0, rs = 0, go = 0, slow = 0;
    logic m_wm_n, m_er_n, flux_n, done, sd_q, sc_q;
    logic [7:0] bytes [0:1] = '{8'hA7, 8'h00};
    // Rows: write_mode_n, erase_enable_n, upper half -> high current, erase, read switch.
    logic [5:0] rows [0:4] = '{6'b110001, 6'b010100, 6'b011000, 6'b100010, 6'b001010};
    int fails = 0, comparisons = 0, ncp = 0, nsc = 0, nsd = 0;
    always #50 mclk = ~mclk;
    disk_rw_flux_codec uut (.mclk(mclk), .rst_n(rst_n), .s_axi_awaddr(awa),
        .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(bre), .s_axi_bvalid(bv),
        .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
        .s_axi_rdata(rd), .s_axi_rresp(rre), .s_axi_rvalid(rv), .s_axi_rready(rr),
        .write_mode_n(tb_wm_n & m_wm_n), .write_flux_pulse_n(flux_n),
        .erase_enable_n(tb_er_n & m_er_n), .power_good_level(pg), .track_upper_half(up),
        .head_select(head_select), .current_sense(cs), .read_square(rs),
        .write_drive_true(wdt), .write_drive_comp(wdc), .high_write_current(hwc),
        .erase_drive(era), .read_switch_on(rsw), .composite_pulse(cp), .sep_clock(sc),
        .sep_data(sd), .write_fault(wf), .write_fault_n(wfn), .drive_ready(rdy),
        .unload_relay_open(rly), .head_driver_return_supply(ret));
    disk_ctrl_model ctrl (.mclk(mclk), .go(go), .slow(slow), .bits(bytes[slow]),
        .write_mode_n(m_wm_n), .erase_enable_n(m_er_n), .write_flux_pulse_n(flux_n),
        .done(done));
    // Counts read pulses and the rising edges of the stretched outputs.
    always @(posedge mclk) begin
        ncp += cp;
        nsc += (sc && !sc_q);
        nsd += (sd && !sd_q);
        sc_q <= sc;
        sd_q <= sd;
    end
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        comparisons++;
        if (s !== e) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task automatic summarize();
        if (fails == 0 && comparisons > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : summarize
    // Address and data go out together; each is dropped once its own ready is seen.
    task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        awa <= a; wd <= d; awv <= 1; wv <= 1; br <= 1;
        do begin
            @(posedge mclk);
            if (awr) awv <= 0;
            if (wr) wv <= 0;
        end while ((awv && !awr) || (wv && !wr));
        while (!bv) @(posedge mclk);
        br <= 0;
        chk("bresp", bre, r);
        @(posedge mclk);
    endtask : axw
    task automatic axr(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
        ara <= a; arv <= 1; rr <= 1;
        do @(posedge mclk); while (!arr);
        arv <= 0;
        while (!rv) @(posedge mclk);
        rr <= 0;
        chk("rdata", rd, e);
        chk("rresp", rre, r);
        @(posedge mclk);
    endtask : axr
    task automatic wt(input int n);
        repeat (n) @(posedge mclk);
    endtask : wt
    task automatic xing(input int n);
        rs <= !rs;
        wt(n);
    endtask : xing
    // Bounds the whole run; normal completion takes well under this.
    initial begin
        wt(20000);
        fails++;
        summarize();
    end
    initial begin
        wt(12);
        rst_n <= 1;
        axr(`REG_WINDOW, `WINDOW_RESET, 2'b00);
        axr(`REG_STRETCH, `STRETCH_RESET, 2'b00);
        axr(`REG_MASK, `MASK_RESET, 2'b00);
        axr(8'h14, 0, 2'b10);
        axw(`REG_STATUS, 1, 2'b10);
        axw(`REG_CONTROL, 1, 2'b00);
        wt(4);
        chk("ready", {rdy, rly, ret}, 3'b101);
        for (int i = 0; i < 5; i++) begin
            {tb_wm_n, tb_er_n, up} <= rows[i][5:3];
            wt(4);
            chk("hicur", hwc, rows[i][2]);
            chk("erase", era, rows[i][1]);
            chk("rdsw", rsw, rows[i][0]);
        end
        {tb_wm_n, tb_er_n} <= 2'b11;
        // Odd pulse count leaves the toggle set, even leaves it clear.
        for (int k = 0; k < 2; k++) begin
            slow <= k[0];
            go <= 1;
            wt(2);
            while (!done) @(posedge mclk);
            chk("wtrue", {wdt, wdc}, k ? 2'b01 : 2'b10);
            go <= 0;
            wt(3);
            chk("erhold", era, 1);
            wt(3);
            chk("wclr", {wdt, wdc}, 2'b00);
        end
        // Clock, data inside the long window, then two lone clocks.
        xing(2);
        xing(8);
        xing(10);
        xing(10);
        chk("comp", ncp, 4);
        chk("sclk", nsc, 3);
        chk("sdat", nsd, 1);
        tb_wm_n <= 0;
        cs <= 1;
        wt(12);
        chk("wrcur", wf, 0);
        tb_wm_n <= 1;
        wt(2);
        chk("mask", wf, 0);
        wt(10);
        chk("stray", {wf, wfn}, 2'b10);
        chk("unld", {rdy, rly, ret}, 3'b010);
        axr(`REG_STATUS, 32'h0000_002B, 2'b00);
        cs <= 0;
        axw(`REG_CONTROL, 1, 2'b00);
        tb_wm_n <= 0;
        head_select <= 8'h03;
        wt(4);
        chk("multi", {wf, wdt, wdc, rdy}, 4'b1000);
        head_select <= 8'h01;
        tb_wm_n <= 1;
        axw(`REG_CONTROL, 1, 2'b00);
        tb_er_n <= 0;
        pg <= 0;
        wt(4);
        chk("pgood", era, 0);
        summarize();
    end
endmodule : disk_rw_flux_codec_and_write_fault_tb
`default_nettype wire
